/* src/sci_lin_pkg.sv */
// Shared constants and carriers for the serial-interface status-2 / control-3 block
package sci_lin_pkg;

   // Register offsets on the plain register port
   localparam logic [1:0] OFS_STATUS2  = 2'h0;
   localparam logic [1:0] OFS_CONTROL3 = 2'h1;
   localparam logic [1:0] OFS_DATA     = 2'h2;

   // Status-2 field positions
   localparam int unsigned S2_LIN_BREAK_FLAG = 7;
   localparam int unsigned S2_RX_EDGE_FLAG   = 6;
   localparam int unsigned S2_RX_INVERT      = 4;
   localparam int unsigned S2_WAKE_IDLE      = 3;
   localparam int unsigned S2_LONG_BREAK     = 2;
   localparam int unsigned S2_LIN_DETECT_EN  = 1;
   localparam int unsigned S2_RX_ACTIVE      = 0;

   // Control-3 field positions
   localparam int unsigned C3_RX_NINTH   = 7;
   localparam int unsigned C3_TX_NINTH   = 6;
   localparam int unsigned C3_TX_DIR     = 5;
   localparam int unsigned C3_TX_INVERT  = 4;
   localparam int unsigned C3_OVERRUN_IE = 3;
   localparam int unsigned C3_NOISE_IE   = 2;
   localparam int unsigned C3_FRAME_IE   = 1;
   localparam int unsigned C3_PARITY_IE  = 0;

   // Reset values
   localparam logic [7:0] STATUS2_RESET  = 8'h00;
   localparam logic [7:0] CONTROL3_RESET = 8'h00;
   localparam logic [7:0] DATA_RESET     = 8'h00;

   // Bit-time counts for break generation and detection
   localparam logic [3:0] BRK_TX_SHORT = 4'hA;
   localparam logic [3:0] BRK_TX_LONG  = 4'hD;
   localparam logic [3:0] BRK_RX_BASE  = 4'hA;

   typedef enum logic {BRK_IDLE, BRK_SEND} tx_brk_e;

   // Events from the receive shifter, all one-cycle pulses except data
   typedef struct packed {
      logic       start_valid;
      logic       idle_detect;
      logic       char_done;
      logic       frame_bad;
      logic       noise;
      logic       parity_bad;
      logic [8:0] data;
   } rx_event_s;

   // Status-1 flags kept by this block
   typedef struct packed {
      logic overrun;
      logic idle;
      logic rx_full;
      logic noise;
      logic frame;
      logic parity;
   } rx_flags_s;

endpackage

/* src/sci_lin_status_and_control3.sv */
// Status-2 / control-3 logic of the serial interface: break, edge, polarity, ninth bits, error requests
// Operation
// - With break detection on, a detected break sets the break flag; write one clears.
// - Active receive edge sets the edge flag, polarity follows receive inversion; write one clears.
// - Receive inversion flips the whole receive input: data, start, stop, break, idle.
// - In standby, a waking idle sets the idle flag only if wake-idle control set.
// - Sent break lasts 10 bit times (11 nine-bit), or 13 (14) with long break.
// - Long-break selection never changes framing-error detection in the receiver.
// - While break detection enabled, framing-error and receive-full flags cannot set.
// - Break recognised after 10 (11) low bit times, or 11 (12) with detection on.
// - Receiver-active flag sets on valid start bit, clears on idle line; read-only.
// - Ninth received bit sits above data MSB; read it before the data register.
// - Data write moves ninth transmit bit with data to shifter; write ninth bit first.
// - In single-wire mode the transmit pin direction follows the direction bit.
// - Transmit inversion flips the whole transmit output: data, start, stop, break, idle.
// - Overrun flag with its enable requests an interrupt; otherwise polling only.
// - Noise flag with its enable requests an interrupt; otherwise none.
// - Framing-error flag with its enable requests an interrupt; otherwise none.
// - Parity-error flag with its enable requests an interrupt; otherwise none.
// - Word length selects 10-bit frame, or 11-bit frame with ninth data bit.
// - Character arriving while buffer still full sets overrun and is discarded.
`timescale 1ns/1ps
module sci_lin_status_and_control3 (
   input  wire logic                   clock,
   input  wire logic                   rst_n,
   input  wire logic [1:0]             reg_addr,
   input  wire logic [7:0]             reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output logic [7:0]                  reg_rdata,
   input  wire logic                   word_len_nine,
   input  wire logic                   receiver_standby,
   input  wire logic                   loop_mode,
   input  wire logic                   receiver_source,
   input  wire logic                   rx_bit_tick,
   input  wire sci_lin_pkg::rx_event_s rx_event,
   input  wire logic                   tx_bit_tick,
   input  wire logic                   tx_break_start,
   input  wire logic                   tx_shift_bit,
   input  wire logic                   rxd_i,
   input  wire logic                   txd_i,
   output logic                        txd_o,
   output logic                        txd_oe,
   output logic                        rx_data,
   output logic                        rx_break,
   output logic                        tx_break_busy,
   output logic                        tx_load,
   output logic [8:0]                  tx_word,
   output sci_lin_pkg::rx_flags_s      rx_flags,
   output logic                        err_irq
);
   import sci_lin_pkg::*;

   logic [1:0] rst_sync_q;
   logic [2:0] rxd_sync_q, txd_sync_q;
   logic [3:0] irq_en_q, rx_low_cnt_q, rx_low_cnt_d, rx_brk_thr, tx_brk_cnt_q, tx_brk_len;
   logic [7:0] serial_data_buffer_q;
   tx_brk_e    tx_brk_state_q;
   logic       rst_sync_n, rxd_stable_q, txd_stable_q, rx_level_q, rx_level_prev_q, rx_brk_hit, rx_src;
   logic       lin_break_flag_q, rx_edge_flag_q, rx_invert_q, wake_idle_sets_flag_q, long_break_select_q;
   logic       lin_break_detect_en_q, receiver_active_flag_q, rx_ninth_bit_q, tx_ninth_bit_q, tx_invert_q;
   logic       single_wire_tx_direction_q, wr_s2, wr_c3, wr_data, rd_data, accept_char, idle_sets;

   // Reset release through two flops; assertion stays asynchronous
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_sync_n = rst_sync_q[1];

   // Address decode of the register port
   always_comb begin
      wr_s2   = 1'b0;
      wr_c3   = 1'b0;
      wr_data = 1'b0;
      rd_data = 1'b0;
      if (reg_addr == OFS_STATUS2) begin
         wr_s2 = reg_wr;
      end else if (reg_addr == OFS_CONTROL3) begin
         wr_c3 = reg_wr;
      end else if (reg_addr == OFS_DATA) begin
         wr_data = reg_wr;
         rd_data = reg_rd;
      end
   end

   // Pin inputs: three stages, a change counts once stages two and three agree
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         rxd_sync_q   <= 3'h7;
         txd_sync_q   <= 3'h7;
         rxd_stable_q <= 1'b1;
         txd_stable_q <= 1'b1;
      end else begin
         rxd_sync_q <= {rxd_sync_q[1:0], rxd_i};
         txd_sync_q <= {txd_sync_q[1:0], txd_i};
         if (rxd_sync_q[1] == rxd_sync_q[2]) begin
            rxd_stable_q <= rxd_sync_q[2];
         end
         if (txd_sync_q[1] == txd_sync_q[2]) begin
            txd_stable_q <= txd_sync_q[2];
         end
      end
   end

   // Receive source: pin, internal loop, or the shared transmit pin in single-wire mode
   always_comb begin
      if (loop_mode && receiver_source) begin
         rx_src = txd_stable_q;
      end else if (loop_mode) begin
         rx_src = txd_o ^ tx_invert_q;
      end else begin
         rx_src = rxd_stable_q;
      end
   end

   // Inversion applies ahead of every receive consumer, so break and idle flip too
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         rx_level_q      <= 1'b1;
         rx_level_prev_q <= 1'b1;
      end else begin
         rx_level_q      <= rx_src ^ rx_invert_q;
         rx_level_prev_q <= rx_level_q;
      end
   end
   assign rx_data = rx_level_q;

   // Break threshold: base ten, plus one for nine-bit frames, plus one for LIN detection
   assign rx_brk_thr   = BRK_RX_BASE + {3'h0, word_len_nine} + {3'h0, lin_break_detect_en_q};
   assign rx_low_cnt_d = (rx_low_cnt_q == 4'hF) ? rx_low_cnt_q : rx_low_cnt_q + 4'h1;
   assign rx_brk_hit   = rx_bit_tick && !rx_level_q && (rx_low_cnt_d == rx_brk_thr);

   // Count consecutive low bit times; a high level ends the run even when no bit ticks arrive
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         rx_low_cnt_q <= 4'h0;
         rx_break     <= 1'b0;
      end else begin
         rx_break <= rx_brk_hit;
         if (rx_level_q) begin
            rx_low_cnt_q <= 4'h0;
         end else if (rx_bit_tick) begin
            rx_low_cnt_q <= rx_low_cnt_d;
         end
      end
   end

   // Status-2 sticky flags; a set in the clearing cycle wins
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         lin_break_flag_q <= STATUS2_RESET[S2_LIN_BREAK_FLAG];
         rx_edge_flag_q   <= STATUS2_RESET[S2_RX_EDGE_FLAG];
      end else begin
         if (rx_brk_hit && lin_break_detect_en_q) begin
            lin_break_flag_q <= 1'b1;
         end else if (wr_s2 && reg_wdata[S2_LIN_BREAK_FLAG]) begin
            lin_break_flag_q <= 1'b0;
         end
         // Falling on the inverted level is the active edge for either polarity
         if (rx_level_prev_q && !rx_level_q) begin
            rx_edge_flag_q <= 1'b1;
         end else if (wr_s2 && reg_wdata[S2_RX_EDGE_FLAG]) begin
            rx_edge_flag_q <= 1'b0;
         end
      end
   end

   // Status-2 control bits
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         rx_invert_q           <= STATUS2_RESET[S2_RX_INVERT];
         wake_idle_sets_flag_q <= STATUS2_RESET[S2_WAKE_IDLE];
         long_break_select_q   <= STATUS2_RESET[S2_LONG_BREAK];
         lin_break_detect_en_q <= STATUS2_RESET[S2_LIN_DETECT_EN];
      end else if (wr_s2) begin
         rx_invert_q           <= reg_wdata[S2_RX_INVERT];
         wake_idle_sets_flag_q <= reg_wdata[S2_WAKE_IDLE];
         long_break_select_q   <= reg_wdata[S2_LONG_BREAK];
         lin_break_detect_en_q <= reg_wdata[S2_LIN_DETECT_EN];
      end
   end

   // Receiver-active: hardware only, writes have no effect
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         receiver_active_flag_q <= STATUS2_RESET[S2_RX_ACTIVE];
      end else if (rx_event.start_valid) begin
         receiver_active_flag_q <= 1'b1;
      end else if (rx_event.idle_detect) begin
         receiver_active_flag_q <= 1'b0;
      end
   end

   // Control-3 bits; the received ninth bit is read-only
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         tx_ninth_bit_q             <= CONTROL3_RESET[C3_TX_NINTH];
         single_wire_tx_direction_q <= CONTROL3_RESET[C3_TX_DIR];
         tx_invert_q                <= CONTROL3_RESET[C3_TX_INVERT];
         irq_en_q                   <= CONTROL3_RESET[3:0];
      end else if (wr_c3) begin
         tx_ninth_bit_q             <= reg_wdata[C3_TX_NINTH];
         single_wire_tx_direction_q <= reg_wdata[C3_TX_DIR];
         tx_invert_q                <= reg_wdata[C3_TX_INVERT];
         irq_en_q                   <= reg_wdata[3:0];
      end
   end

   // Break detection enable blocks loading; long-break select plays no part here
   assign accept_char = rx_event.char_done && !lin_break_detect_en_q;
   // Standby idle only flags when asked to
   assign idle_sets = rx_event.idle_detect && (!receiver_standby || wake_idle_sets_flag_q);

   // Receive buffer and status-1 flags; a data read clears, a new event in that cycle wins
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         serial_data_buffer_q <= DATA_RESET;
         rx_ninth_bit_q       <= CONTROL3_RESET[C3_RX_NINTH];
         rx_flags             <= '0;
      end else begin
         if (rd_data) begin
            rx_flags <= '0;
         end
         if (idle_sets) begin
            rx_flags.idle <= 1'b1;
         end
         if (accept_char && rx_flags.rx_full && !rd_data) begin
            rx_flags.overrun <= 1'b1;
         end else if (accept_char) begin
            serial_data_buffer_q <= rx_event.data[7:0];
            rx_ninth_bit_q       <= word_len_nine ? rx_event.data[8] : 1'b0;
            rx_flags.rx_full     <= 1'b1;
            rx_flags.frame       <= rx_event.frame_bad;
            rx_flags.noise       <= rx_event.noise;
            rx_flags.parity      <= rx_event.parity_bad;
         end
      end
   end

   // Data write hands the whole nine-bit word to the shifter in one pulse
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         tx_load <= 1'b0;
         tx_word <= 9'h000;
      end else begin
         tx_load <= wr_data;
         if (wr_data) begin
            tx_word <= {word_len_nine & tx_ninth_bit_q, reg_wdata};
         end
      end
   end

   assign tx_brk_len = (long_break_select_q ? BRK_TX_LONG : BRK_TX_SHORT) + {3'h0, word_len_nine};

   // Break generator: length latched at start, counts transmit bit ticks down
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         tx_brk_state_q <= BRK_IDLE;
         tx_brk_cnt_q   <= 4'h0;
         tx_break_busy  <= 1'b0;
      end else begin
         case (tx_brk_state_q)
            BRK_IDLE: begin
               if (tx_break_start) begin
                  tx_brk_state_q <= BRK_SEND;
                  tx_brk_cnt_q   <= tx_brk_len;
                  tx_break_busy  <= 1'b1;
               end
            end
            BRK_SEND: begin
               if (tx_bit_tick) begin
                  tx_brk_cnt_q <= tx_brk_cnt_q - 4'h1;
                  if (tx_brk_cnt_q == 4'h1) begin
                     tx_brk_state_q <= BRK_IDLE;
                     tx_break_busy  <= 1'b0;
                  end
               end
            end
            default: begin
               tx_brk_state_q <= BRK_IDLE;
            end
         endcase
      end
   end

   // Transmit pin; inversion sits last so break and idle flip as well
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         txd_o  <= 1'b1;
         txd_oe <= 1'b1;
      end else begin
         txd_o <= ((tx_brk_state_q == BRK_SEND) ? 1'b0 : tx_shift_bit) ^ tx_invert_q;
         if (loop_mode && receiver_source) begin
            txd_oe <= single_wire_tx_direction_q;
         end else begin
            txd_oe <= 1'b1;
         end
      end
   end

   // One error request, held while any enabled flag stays set
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         err_irq <= 1'b0;
      end else begin
         err_irq <= (rx_flags.overrun && irq_en_q[C3_OVERRUN_IE])
                  || (rx_flags.noise && irq_en_q[C3_NOISE_IE])
                  || (rx_flags.frame && irq_en_q[C3_FRAME_IE])
                  || (rx_flags.parity && irq_en_q[C3_PARITY_IE]);
      end
   end

   // Read data stand for one cycle only; reading status does not disturb flags
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd && reg_addr == OFS_STATUS2) begin
         reg_rdata <= {lin_break_flag_q, rx_edge_flag_q, 1'b0, rx_invert_q, wake_idle_sets_flag_q,
                       long_break_select_q, lin_break_detect_en_q, receiver_active_flag_q};
      end else if (reg_rd && reg_addr == OFS_CONTROL3) begin
         reg_rdata <= {rx_ninth_bit_q, tx_ninth_bit_q, single_wire_tx_direction_q, tx_invert_q, irq_en_q};
      end else if (rd_data) begin
         reg_rdata <= serial_data_buffer_q;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_sync_n);

   sequence s_brk_start;
      (tx_brk_state_q == BRK_IDLE) && tx_break_start;
   endsequence
   sequence s_brk_end;
      (tx_brk_state_q == BRK_SEND) && tx_bit_tick && tx_brk_cnt_q == 4'h1;
   endsequence

   property p_lin_flag_set;
      rx_brk_hit && lin_break_detect_en_q |=> lin_break_flag_q;
   endproperty
   a_lin_flag_set: assert property (p_lin_flag_set) else $error("break flag not set");
   property p_edge_flag;
      rx_level_prev_q && !rx_level_q |=> rx_edge_flag_q;
   endproperty
   a_edge_flag: assert property (p_edge_flag) else $error("edge flag not set");
   property p_rx_inv_apply;
      ##1 1'b1 |-> rx_level_q == ($past(rx_src) ^ $past(rx_invert_q));
   endproperty
   a_rx_inv_apply: assert property (p_rx_inv_apply) else $error("receive polarity wrong");
   property p_idle_standby;
      rx_event.idle_detect && receiver_standby && !wake_idle_sets_flag_q && !rx_flags.idle |=> !rx_flags.idle;
   endproperty
   a_idle_standby: assert property (p_idle_standby) else $error("standby idle set flag");
   property p_brk_len;
      s_brk_start |=> tx_brk_cnt_q == $past(tx_brk_len) && tx_break_busy;
   endproperty
   a_brk_len: assert property (p_brk_len) else $error("break length wrong");
   property p_brk_done;
      s_brk_end |=> !tx_break_busy && tx_brk_state_q == BRK_IDLE;
   endproperty
   a_brk_done: assert property (p_brk_done) else $error("break did not end");
   property p_tx_invert;
      tx_brk_state_q == BRK_SEND |=> txd_o == $past(tx_invert_q);
   endproperty
   a_tx_invert: assert property (p_tx_invert) else $error("break polarity wrong");
   property p_block_full;
      lin_break_detect_en_q && !rx_flags.rx_full |=> !rx_flags.rx_full;
   endproperty
   a_block_full: assert property (p_block_full) else $error("full flag set during break detect");
   property p_raf;
      rx_event.start_valid |=> receiver_active_flag_q;
   endproperty
   a_raf: assert property (p_raf) else $error("active flag not set");
   property p_dir;
      loop_mode && receiver_source |=> txd_oe == $past(single_wire_tx_direction_q);
   endproperty
   a_dir: assert property (p_dir) else $error("single-wire direction wrong");
   property p_overrun;
      accept_char && rx_flags.rx_full && !rd_data |=> rx_flags.overrun && $stable(serial_data_buffer_q);
   endproperty
   a_overrun: assert property (p_overrun) else $error("overrun not handled");
   property p_irq;
      rx_flags.frame && irq_en_q[C3_FRAME_IE] ##1 rx_flags.frame |-> err_irq;
   endproperty
   a_irq: assert property (p_irq) else $error("error request missing");

endmodule

/* bench/remote_node.sv */
// Remote serial node: holds the receive line and paces receive bit times
`timescale 1ns/1ps
module remote_node (
   input  wire logic clock,
   input  wire logic invert,
   input  wire logic space,
   output logic      rxd,
   output logic      bit_tick
);
   logic [7:0] cnt = 8'h00;
   // Mark when idle, space when asked; the pin level follows the chosen polarity
   assign rxd = ~space ^ invert;
   // Bit times start late so the design's synchroniser has settled first
   always_ff @(posedge clock) begin
      cnt      <= space ? cnt + 8'h01 : 8'h00;
      bit_tick <= space && (cnt[2:0] == 3'h7);
   end
endmodule

/* bench/testbench.sv */
// Self-checking bench for the status-2 / control-3 serial block
`timescale 1ns/1ps
module testbench;
   import sci_lin_pkg::*;
   logic       clock = 1'b0;
   logic       rst_n = 1'b0;
   logic [1:0] reg_addr = 2'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   logic       word_len_nine = 1'b0;
   logic       receiver_standby = 1'b0;
   logic       loop_mode = 1'b0;
   logic       receiver_source = 1'b0;
   rx_event_s  rx_event = '0;
   logic       tx_bit_tick = 1'b0;
   logic       tx_break_start = 1'b0;
   logic       tx_shift_bit = 1'b1;
   logic       space = 1'b0;
   logic       rx_inv = 1'b0;
   logic [2:0] tx_div = 3'h0;
   logic [7:0] reg_rdata, rv, en;
   logic [8:0] tx_word, d9;
   rx_flags_s  rx_flags;
   logic       rx_bit_tick, rxd_i, txd_o, txd_oe, rx_data, rx_break, tx_break_busy, tx_load, err_irq;
   int         n_errors = 0;
   int         n_tests = 0;
   int         seed = 32'h442503EC;
   int         k;

   initial begin
      forever #10 clock = ~clock;
   end

   // Transmit bit times every 4 clocks; the raw shifter level is random
   always @(posedge clock) begin
      tx_div <= tx_div + 3'h1;
      tx_bit_tick <= (tx_div[1:0] == 2'h3);
      tx_shift_bit <= 1'($random(seed));
   end

   sci_lin_status_and_control3 sci_lin_status_and_control3_i (.clock(clock), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .word_len_nine(word_len_nine), .receiver_standby(receiver_standby), .loop_mode(loop_mode),
      .receiver_source(receiver_source), .rx_bit_tick(rx_bit_tick), .rx_event(rx_event),
      .tx_bit_tick(tx_bit_tick), .tx_break_start(tx_break_start), .tx_shift_bit(tx_shift_bit),
      .rxd_i(rxd_i), .txd_i(1'b1), .txd_o(txd_o), .txd_oe(txd_oe), .rx_data(rx_data), .rx_break(rx_break),
      .tx_break_busy(tx_break_busy), .tx_load(tx_load), .tx_word(tx_word), .rx_flags(rx_flags), .err_irq(err_irq));
   remote_node remote_node_i (.clock(clock), .invert(rx_inv), .space(space), .rxd(rxd_i), .bit_tick(rx_bit_tick));

   task automatic give_verdict();
      $display("tests %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [1:0] a, output logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      // Taken at the edge that closes the data cycle, before the port drops it
      @(posedge clock);
      d = reg_rdata;
   endtask

   task automatic pulse(input logic [14:0] v);
      @(posedge clock);
      rx_event <= v;
      @(posedge clock);
      rx_event <= '0;
      repeat (2) @(posedge clock);
   endtask

   // Send one break and count the bit times it lasts
   task automatic tx_brk(input logic lng, input logic nine, input logic inv);
      int n;
      int i;
      n = 0;
      word_len_nine <= nine;
      wr(OFS_STATUS2, {5'h0, lng, 2'h0});
      wr(OFS_CONTROL3, {3'h0, inv, 4'h0});
      @(posedge clock);
      tx_break_start <= 1'b1;
      @(posedge clock);
      tx_break_start <= 1'b0;
      for (i = 0; i < 300 && (i < 2 || tx_break_busy === 1'b1); i++) begin
         @(posedge clock);
         if (tx_bit_tick === 1'b1 && tx_break_busy === 1'b1) n++;
         if (i == 3) chk(9'(txd_o), 9'(inv));
      end
      if (tx_break_busy === 1'b1) begin
         n_errors++;
         give_verdict();
      end
      chk(9'(n), 9'((lng ? 13 : 10) + nine));
      $display("tx break long %0d nine %0d inv %0d done", lng, nine, inv);
   endtask

   // Hold the line in space and count bit times until the break is seen
   task automatic rx_brk(input logic lin, input logic nine, input logic inv);
      logic [7:0] cfg;
      int n;
      int i;
      n = 0;
      cfg = {3'h0, inv, 2'h0, lin, 1'b0};
      word_len_nine <= nine;
      rx_inv <= inv;
      wr(OFS_STATUS2, cfg);
      repeat (6) @(posedge clock);
      wr(OFS_STATUS2, 8'hC0 | cfg);
      space <= 1'b1;
      for (i = 0; i < 300 && rx_break !== 1'b1; i++) begin
         @(posedge clock);
         if (rx_bit_tick === 1'b1) n++;
      end
      if (i == 300) begin
         n_errors++;
         give_verdict();
      end
      chk(9'(n), 9'(10 + lin + nine));
      chk(9'(rx_data), 9'h0);
      space <= 1'b0;
      repeat (6) @(posedge clock);
      rd(OFS_STATUS2, rv);
      chk(9'(rv[7:6]), {7'h0, lin, 1'b1});
      wr(OFS_STATUS2, 8'hC0 | cfg);
      rd(OFS_STATUS2, rv);
      chk(9'(rv[7:6]), 9'h0);
      $display("rx break lin %0d nine %0d inv %0d done", lin, nine, inv);
   endtask

   initial begin
      repeat (5) @(posedge clock);
      rst_n <= 1'b1;
      repeat (3) @(posedge clock);
      rd(OFS_STATUS2, rv);
      chk(9'(rv), 9'(STATUS2_RESET));
      rd(OFS_CONTROL3, rv);
      chk(9'(rv), 9'(CONTROL3_RESET));
      // Random register traffic, including the unmapped offset
      for (k = 0; k < 8; k++) begin
         en = 8'($random(seed));
         wr(OFS_CONTROL3, en);
         rd(OFS_CONTROL3, rv);
         chk(9'(rv), 9'(en & 8'h7F));
         wr(OFS_STATUS2, en);
         rd(OFS_STATUS2, rv);
         chk(9'(rv & 8'h1F), 9'(en & 8'h1E));
         rd(2'h3, rv);
         chk(9'(rv), 9'h0);
      end
      $display("register access done");
      for (k = 0; k < 8; k++) tx_brk(k[0], k[1], k[2]);
      for (k = 0; k < 8; k++) rx_brk(k[0], k[1], k[2]);
      rx_inv <= 1'b0;
      wr(OFS_STATUS2, 8'hC0);
      wr(OFS_CONTROL3, 8'h0F);
      word_len_nine <= 1'b1;
      d9 = 9'($random(seed));
      pulse(15'h4000);
      rd(OFS_STATUS2, rv);
      chk(9'(rv[0]), 9'h1);
      // Second character with every error arrives before the first is read
      pulse({6'b001000, d9});
      pulse({6'b001111, ~d9});
      chk(9'(rx_flags), 9'(6'b101000));
      chk(9'(err_irq), 9'h1);
      rd(OFS_CONTROL3, rv);
      chk(9'(rv[7]), 9'(d9[8]));
      rd(OFS_DATA, rv);
      chk(9'(rv), 9'(d9[7:0]));
      repeat (2) @(posedge clock);
      chk({2'h0, rx_flags, err_irq}, 9'h0);
      wr(OFS_STATUS2, 8'h04);
      for (k = 0; k < 3; k++) begin
         en = (k == 0) ? 8'h01 : (k == 1) ? 8'h04 : 8'h02;
         wr(OFS_CONTROL3, ~en & 8'h0F);
         pulse(15'h1000 | (15'h0200 << k));
         chk(9'(err_irq), 9'h0);
         wr(OFS_CONTROL3, en);
         repeat (2) @(posedge clock);
         chk(9'(err_irq), 9'h1);
         rd(OFS_DATA, rv);
      end
      $display("receive flags done");
      wr(OFS_STATUS2, 8'h02);
      pulse(15'h1800);
      chk(9'({rx_flags.rx_full, rx_flags.frame}), 9'h0);
      receiver_standby <= 1'b1;
      wr(OFS_STATUS2, 8'h00);
      pulse(15'h2000);
      chk(9'(rx_flags.idle), 9'h0);
      wr(OFS_STATUS2, 8'h08);
      pulse(15'h2000);
      chk(9'(rx_flags.idle), 9'h1);
      rd(OFS_STATUS2, rv);
      chk(9'(rv[0]), 9'h0);
      receiver_standby <= 1'b0;
      // The ninth transmit bit travels with the data word
      wr(OFS_CONTROL3, 8'h40);
      en = 8'($random(seed));
      wr(OFS_DATA, en);
      for (k = 0; k < 4 && tx_load !== 1'b1; k++) @(posedge clock);
      if (tx_load !== 1'b1) begin
         n_errors++;
         give_verdict();
      end
      chk(tx_word, {1'b1, en});
      loop_mode <= 1'b1;
      receiver_source <= 1'b1;
      wr(OFS_CONTROL3, 8'h00);
      repeat (3) @(posedge clock);
      chk(9'(txd_oe), 9'h0);
      wr(OFS_CONTROL3, 8'h20);
      repeat (3) @(posedge clock);
      chk(9'(txd_oe), 9'h1);
      $display("transmit and direction done");
      give_verdict();
   end
endmodule
